/* design/pwpm_defines.svh */
// constants for password entry and page mapping block
`ifndef PWPM_DEFINES_SVH
`define PWPM_DEFINES_SVH
`define PWPM_ADDR_NEW_PW 8'h76
`define PWPM_ADDR_SUBMIT_PW 8'h7A
`define PWPM_ADDR_BANK 8'h7E
`define PWPM_ADDR_PAGE 8'h7F
`define PWPM_ADDR_RESULT 8'h2A
`define PWPM_ADDR_CAP 8'h97
`define PWPM_ADDR_UPPER_MIN 8'h80
`define PWPM_HOST_PW_RESET 32'h0000_1011
`define PWPM_MODULE_PW_RESET 32'h8000_0000
`define PWPM_PW_MSB 31
`define PWPM_RES_IDLE 4'h0
`define PWPM_RES_BUSY 4'h1
`define PWPM_RES_ACCEPT 4'h2
`define PWPM_RES_REJECT 4'h3
`define PWPM_RES_CHANGED 4'h4
`define PWPM_CAP_SUPPORTED 2'h1
`define PWPM_CAP_LSB 4
`define PWPM_CAP_PAGE 8'h01
`define PWPM_VALIDATE_CYCLES 4'h4
`define PWPM_SWITCH_CYCLES 4'h3
`define PWPM_REG_CMD 2'h0
`define PWPM_REG_STAT 2'h1
`define PWPM_REG_DATA 2'h2
`define PWPM_REG_RDATA 2'h3
`endif

/* design/pwpm_pkg.sv */
// types shared by both ends of the management link
`default_nettype none
package pwpm_pkg;
    typedef enum logic [1:0] {
        PWPM_OP_NONE,
        PWPM_OP_READ,
        PWPM_OP_WRITE
    } pwpm_op_t;
endpackage
`default_nettype wire

/* design/pwpm_link_if.sv */
// byte management link between host controller and module
`default_nettype none
interface pwpm_link_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [2:0] len;
    logic [31:0] wdata;
    logic ack;
    logic reject;
    logic [7:0] rdata;
    modport host (output req, wr, addr, len, wdata,
        input ack, reject, rdata);
    modport module_end (input req, wr, addr, len, wdata,
        output ack, reject, rdata);
endinterface
`default_nettype wire

/* design/pwpm_page_map.sv */
// page mapping register with deferred bank and switch timer
`include "pwpm_defines.svh"
`default_nettype none
module pwpm_page_map #(
    parameter logic [7:0] MAX_PAGE = 8'h03,
    parameter logic [7:0] MAX_BANK = 8'h00
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_bank,
    input wire logic wr_page,
    input wire logic [7:0] bank_in,
    input wire logic [7:0] page_in,
    output logic [7:0] bank_index_reg,
    output logic [7:0] page_index_reg,
    output logic switching
);
    logic [3:0] sw_cnt_reg;
    logic supported;
    // pages 10h and up banked; below unbanked so bank ignored
    always_comb begin
        if (page_in >= 8'h10) begin
            supported = (page_in <= MAX_PAGE) && (bank_in <= MAX_BANK);
        end else begin
            supported = (page_in <= MAX_PAGE);
        end
    end
    // bank held until page byte written
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_index_reg <= 8'h00;
        end else if (wr_page && wr_bank) begin
            bank_index_reg <= bank_in;
        end
    end
    // unsupported mapping falls back to page 00h
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_index_reg <= 8'h00;
        end else if (wr_page) begin
            page_index_reg <= supported ? page_in : 8'h00;
        end
    end
    // every page write runs a bounded switch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sw_cnt_reg <= 4'h0;
        end else if (wr_page) begin
            sw_cnt_reg <= `PWPM_SWITCH_CYCLES;
        end else if (sw_cnt_reg != 4'h0) begin
            sw_cnt_reg <= sw_cnt_reg - 4'h1;
        end
    end
    assign switching = (sw_cnt_reg != 4'h0);
endmodule
`default_nettype wire

/* design/pwpm_module.sv */
// module end: password lock and page mapping registers
//
// Decided for this implementation: the strobed register port.
`include "pwpm_defines.svh"
`default_nettype none
module pwpm_module #(
    parameter logic [31:0] MODULE_PW = `PWPM_MODULE_PW_RESET,
    parameter logic [7:0] MAX_PAGE = 8'h03,
    parameter logic [7:0] MAX_BANK = 8'h00,
    parameter logic PW_SUPPORTED = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    pwpm_link_if.module_end link,
    input wire logic mgmt_init,
    output logic unlocked,
    output logic [7:0] map_bank,
    output logic [7:0] map_page,
    output logic map_busy
);
    import pwpm_pkg::*;
    logic [31:0] host_pw_reg;
    logic [31:0] cand_reg;
    logic is_change_reg;
    logic [3:0] val_cnt_reg;
    logic [3:0] result_reg;
    logic unlocked_reg;
    logic pw_wr, chg_wr, bank_wr, page_wr, word_ok;
    logic upper, reject;
    logic [7:0] rdata_next;
    logic [7:0] bank_in, page_in;
    logic validating;
    logic result_early;
    logic host_match, module_match, cand_valid;
    logic change_ok, final_step, start_val;
    logic entry_rd, cap_rd;

    assign validating = (val_cnt_reg != 4'h0);
    assign upper = (link.addr >= `PWPM_ADDR_UPPER_MIN);
    // result not stored yet while validating
    assign result_early = !link.wr && (link.addr == `PWPM_ADDR_RESULT)
        && validating;
    // whole memory refused while switching, upper may be stale
    always_comb begin
        reject = 1'b0;
        if (map_busy) begin
            reject = 1'b1;
        end else if (result_early) begin
            reject = 1'b1;
        end
    end
    assign word_ok = link.req && link.wr && !reject
        && (link.len == 3'd4) && PW_SUPPORTED;
    assign pw_wr = word_ok && (link.addr == `PWPM_ADDR_SUBMIT_PW);
    assign chg_wr = word_ok && (link.addr == `PWPM_ADDR_NEW_PW);
    // entry arriving while validating is dropped
    assign start_val = (pw_wr || chg_wr) && !validating;
    // last validation cycle settles the outcome
    assign final_step = (val_cnt_reg == 4'h1);
    assign host_match = (cand_reg == host_pw_reg);
    assign module_match = (cand_reg == MODULE_PW);
    assign cand_valid = host_match || module_match;
    // change needs unlock and a host-range value
    assign change_ok = unlocked_reg && !cand_reg[`PWPM_PW_MSB];
    // bank write from 126 with length 2, page from either
    always_comb begin
        bank_wr = 1'b0;
        page_wr = 1'b0;
        bank_in = link.wdata[31:24];
        page_in = link.wdata[31:24];
        if (link.req && link.wr && !reject) begin
            if (link.addr == `PWPM_ADDR_BANK && link.len == 3'd2) begin
                bank_wr = 1'b1;
                page_wr = 1'b1;
                page_in = link.wdata[23:16];
            end else if (link.addr == `PWPM_ADDR_PAGE
                    && link.len == 3'd1) begin
                page_wr = 1'b1;
                bank_in = map_bank;
            end
        end
    end

    pwpm_page_map #(.MAX_PAGE(MAX_PAGE), .MAX_BANK(MAX_BANK)) u_map (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_bank(bank_wr),
        .wr_page(page_wr),
        .bank_in(bank_in),
        .page_in(page_in),
        .bank_index_reg(map_bank),
        .page_index_reg(map_page),
        .switching(map_busy)
    );

    // candidate held internally, entry bytes read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cand_reg <= 32'h0000_0000;
        end else if (start_val) begin
            cand_reg <= link.wdata;
        end
    end
    // remembers which area started the validation
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            is_change_reg <= 1'b0;
        end else if (start_val) begin
            is_change_reg <= chg_wr;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            val_cnt_reg <= 4'h0;
        end else if (start_val) begin
            val_cnt_reg <= `PWPM_VALIDATE_CYCLES;
        end else if (validating) begin
            val_cnt_reg <= val_cnt_reg - 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            host_pw_reg <= `PWPM_HOST_PW_RESET;
        end else if (final_step && is_change_reg && change_ok) begin
            host_pw_reg <= cand_reg;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unlocked_reg <= 1'b0;
        end else if (mgmt_init) begin
            unlocked_reg <= 1'b0;
        end else if (final_step && !is_change_reg) begin
            unlocked_reg <= cand_valid;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= `PWPM_RES_IDLE;
        end else if (start_val) begin
            result_reg <= `PWPM_RES_BUSY;
        end else if (final_step) begin
            if (is_change_reg) begin
                result_reg <= change_ok ? `PWPM_RES_CHANGED
                    : `PWPM_RES_REJECT;
            end else if (cand_valid) begin
                result_reg <= `PWPM_RES_ACCEPT;
            end else begin
                result_reg <= `PWPM_RES_REJECT;
            end
        end
    end
    // entry areas are write-only and read back as zero
    assign entry_rd = (link.addr >= `PWPM_ADDR_NEW_PW)
        && (link.addr < `PWPM_ADDR_BANK);
    // capability byte sits in page 01h of the window
    assign cap_rd = upper && (map_page == `PWPM_CAP_PAGE)
        && (link.addr == `PWPM_ADDR_CAP);
    // read mux; other window bytes return mapped page id
    always_comb begin
        rdata_next = 8'h00;
        if (cap_rd) begin
            rdata_next = PW_SUPPORTED
                ? (8'(`PWPM_CAP_SUPPORTED) << `PWPM_CAP_LSB) : 8'h00;
        end else if (upper) begin
            rdata_next = map_page;
        end else if (entry_rd) begin
            rdata_next = 8'h00;
        end else if (link.addr == `PWPM_ADDR_RESULT) begin
            rdata_next = {4'h0, result_reg};
        end else if (link.addr == `PWPM_ADDR_BANK) begin
            rdata_next = map_bank;
        end else if (link.addr == `PWPM_ADDR_PAGE) begin
            rdata_next = map_page;
        end
    end
    // read byte only beside an accepted read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.rdata <= 8'h00;
        end else begin
            link.rdata <= (link.req && !link.wr && !reject)
                ? rdata_next : 8'h00;
        end
    end
    // one answer per request, ack or reject
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.ack <= 1'b0;
        end else begin
            link.ack <= link.req && !reject;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.reject <= 1'b0;
        end else begin
            link.reject <= link.req && reject;
        end
    end
    assign unlocked = unlocked_reg;
endmodule
`default_nettype wire

/* design/pwpm_host.sv */
// host end: register-commanded management link master
`include "pwpm_defines.svh"
`default_nettype none
module pwpm_host (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    pwpm_link_if.host link
);
    import pwpm_pkg::*;
    logic [31:0] data_reg;
    logic [7:0] rd_byte_reg;
    logic busy_reg, rej_reg;
    pwpm_op_t op_next;
    // cmd word: [7:0] address, [10:8] length, [12] write
    always_comb begin
        op_next = PWPM_OP_NONE;
        if (wr_en && addr == `PWPM_REG_CMD && !busy_reg) begin
            op_next = wdata[12] ? PWPM_OP_WRITE : PWPM_OP_READ;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= 32'h0000_0000;
        end else if (wr_en && addr == `PWPM_REG_DATA) begin
            data_reg <= wdata;
        end
    end
    // whole word sent in one access, msb first
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.req <= 1'b0;
            link.wr <= 1'b0;
            link.addr <= 8'h00;
            link.len <= 3'd0;
            link.wdata <= 32'h0000_0000;
        end else begin
            link.req <= (op_next != PWPM_OP_NONE);
            if (op_next != PWPM_OP_NONE) begin
                link.wr <= (op_next == PWPM_OP_WRITE);
                link.addr <= wdata[7:0];
                link.len <= wdata[10:8];
                link.wdata <= data_reg;
            end
        end
    end
    // busy until answer so no overlap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            rej_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
        end else if (op_next != PWPM_OP_NONE) begin
            busy_reg <= 1'b1;
        end else if (link.ack || link.reject) begin
            busy_reg <= 1'b0;
            rej_reg <= link.reject;
            rd_byte_reg <= link.rdata;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                `PWPM_REG_STAT: rdata <= {30'h0, rej_reg, busy_reg};
                `PWPM_REG_DATA: rdata <= data_reg;
                `PWPM_REG_RDATA: rdata <= {24'h0, rd_byte_reg};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* tb/pwpm_chk.sv */
// assertions on the management link and module outputs
`default_nettype none
module pwpm_chk #(
    parameter logic [7:0] MAX_PAGE = 8'h03
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [2:0] len,
    input wire logic ack,
    input wire logic reject,
    input wire logic [7:0] rdata,
    input wire logic mgmt_init,
    input wire logic unlocked,
    input wire logic [7:0] map_page,
    input wire logic map_busy
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence switch_s;
        map_busy [*3] ##1 !map_busy;
    endsequence
    sequence free_rd_s;
        req && !wr && !map_busy;
    endsequence
    answer_once_a: assert property (req |=> ack != reject)
        else $error("link answer missing or doubled");
    busy_reject_a: assert property (req && map_busy |=> reject)
        else $error("access taken during page switch");
    switch_len_a: assert property ($rose(map_busy) |-> switch_s)
        else $error("page switch length wrong");
    page_start_a: assert property (req && wr && addr == 8'h7F &&
        len == 3'h1 && !map_busy |=> ack ##[0:2] map_busy)
        else $error("page write did not start a switch");
    page_valid_a: assert property (map_page <= MAX_PAGE)
        else $error("unsupported page mapped");
    lock_init_a: assert property (mgmt_init |=> !unlocked)
        else $error("unlocked during init");
    window_map_a: assert property (free_rd_s ##0 addr[7]
        && !(addr == 8'h97 && map_page == 8'h01)
        |=> ack && rdata == map_page)
        else $error("upper window not routed by mapping");
    cap_field_a: assert property (free_rd_s ##0 addr == 8'h97
        && map_page == 8'h01 |=> ack && rdata[5:4] == 2'h1)
        else $error("capability field wrong");
    pw_write_a: assert property (req && wr && addr == 8'h7A
        && !map_busy |=> ack)
        else $error("password write not answered");
endmodule
`default_nettype wire

/* tb/tb_password_and_page_mapping.sv */
// self-checking bench for both ends of the management link
`default_nettype none
module tb_password_and_page_mapping;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, wr_en, rd_en, mgmt_init, unlocked, map_busy;
    logic [1:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] map_bank, map_page;
    int mismatches = 0;
    int n_tests = 0;
    pwpm_link_if link();
    pwpm_module u_pwpm_module (.clk_sys(clk_sys), .rst_n(rst_n),
        .link(link), .mgmt_init(mgmt_init), .unlocked(unlocked),
        .map_bank(map_bank), .map_page(map_page), .map_busy(map_busy));
    pwpm_host u_pwpm_host (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .link(link));
    pwpm_chk u_pwpm_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req(link.req),
        .wr(link.wr), .addr(link.addr), .len(link.len), .ack(link.ack),
        .reject(link.reject), .rdata(link.rdata), .mgmt_init(mgmt_init),
        .unlocked(unlocked), .map_page(map_page), .map_busy(map_busy));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic stat_wait(output logic rej, output logic [7:0] b);
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
            rd_reg(2'h1, s);
        check(s[0], 1'b0);
        rej = s[1];
        rd_reg(2'h3, s);
        b = s[7:0];
    endtask
    task automatic link_op(input logic [7:0] a, input logic [2:0] n,
            input logic w, input logic [31:0] d, output logic rej,
            output logic [7:0] b);
        wr_reg(2'h2, d);
        wr_reg(2'h0, {19'h0, w, 1'b0, n, a});
        stat_wait(rej, b);
    endtask
    task automatic pw_step(input logic [7:0] a, input logic [2:0] n,
            input logic [31:0] v, input logic [3:0] code, input logic ul);
        logic rej;
        logic [7:0] b;
        link_op(a, n, 1'b1, v, rej, b);
        rej = 1'b1;
        // poll result until the read is no longer refused
        for (int i = 0; i < 8 && rej !== 1'b0; i++)
            link_op(8'h2A, 3'h1, 1'b0, 32'h0, rej, b);
        check(b[3:0], code);
        check(unlocked, ul);
    endtask
    task automatic t_reset();
        logic rej;
        logic [7:0] b;
        check({unlocked, map_bank, map_page}, 17'h0);
        // page-only write maps page 01h, home of the capability
        link_op(8'h7F, 3'h1, 1'b1, 32'h0100_0000, rej, b);
        link_op(8'h97, 3'h1, 1'b0, 32'h0, rej, b);
        check({rej, b[5:4]}, 3'h1);
    endtask
    task automatic t_password();
        pw_step(8'h7A, 3'h4, 32'h0000_1012, 4'h3, 1'b0);
        pw_step(8'h7A, 3'h2, 32'h0000_1011, 4'h3, 1'b0);
        pw_step(8'h7A, 3'h4, 32'h0000_1011, 4'h2, 1'b1);
        pw_step(8'h76, 3'h4, 32'h8000_0001, 4'h3, 1'b1);
        pw_step(8'h76, 3'h4, 32'h0000_2222, 4'h4, 1'b1);
        pw_step(8'h7A, 3'h4, 32'h0000_1011, 4'h3, 1'b0);
        pw_step(8'h7A, 3'h4, 32'h0000_2222, 4'h2, 1'b1);
        @(posedge clk_sys);
        mgmt_init <= 1'b1;
        repeat (2) @(posedge clk_sys);
        mgmt_init <= 1'b0;
        check(unlocked, 1'b0);
        pw_step(8'h7A, 3'h4, 32'h8000_0000, 4'h2, 1'b1);
    endtask
    task automatic t_page();
        logic rej;
        logic [7:0] b;
        link_op(8'h7F, 3'h1, 1'b1, 32'h0200_0000, rej, b);
        repeat (4) @(posedge clk_sys);
        link_op(8'hC5, 3'h1, 1'b0, 32'h0, rej, b);
        check({rej, b}, 9'h002);
        link_op(8'h7E, 3'h1, 1'b1, 32'h0500_0000, rej, b);
        repeat (4) @(posedge clk_sys);
        check(map_bank, 8'h00);
        link_op(8'h7E, 3'h2, 1'b1, 32'h0509_0000, rej, b);
        repeat (4) @(posedge clk_sys);
        check({map_bank, map_page}, 16'h0500);
        // page write, then a window read issued while the switch runs
        wr_reg(2'h2, 32'h0100_0000);
        wr_reg(2'h0, 32'h0000_117F);
        // host takes the next command once the write is answered
        @(posedge clk_sys);
        wr_reg(2'h0, 32'h0000_0180);
        stat_wait(rej, b);
        check(rej, 1'b1);
        repeat (4) @(posedge clk_sys);
        check(map_page, 8'h01);
    endtask
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        mgmt_init = 1'b0;
        addr = 2'h0;
        wdata = 32'h0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_password();
        t_page();
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
